/* core/lpd_defs.vh */
// Constants for the light-pen detect and address back-step block.
// Operation
// - Detection allowed only with foot switch active and start code 82 hex in B register.
// - Photocell pulse is synchronised while foot switch is down; sets pen detect trigger.
// - Nonbuffered unit sets unit check when byte counter loop reaches zero.
// - Buffered unit sets unit check only after all address decrements are done.
// - On detection: step address back (buffered only), then halt regeneration; attention is set together with the halt, buffered only.
// - Channel then issues Sense; device reports pen activity and corrected address.
// - Pen sampled before character code, before coordinate transfer, before mode latch reset.
// - Address counter increments after every buffer byte read during regeneration.
// - Character mode detection steps the address counter back two.
// - Graphic mode detection steps the address counter back eight.
// - Detection at a mode-select code keeps the mode latches set.
// - At mode-select code: back five after graphic mode, two after character mode.
`ifndef LPD_DEFS_VH
`define LPD_DEFS_VH
`define LPD_START_CODE   8'h82
`define LPD_BACK_CHAR    4'h2
`define LPD_BACK_GRAPH   4'h8
`define LPD_BACK_SM_GR   4'h5
`define LPD_ADDR_RST     12'h000
`define LPD_ADDR_W       12
// Register offsets.
`define LPD_REG_CTRL     4'h0
`define LPD_REG_STATUS   4'h1
`define LPD_REG_ADDR     4'h2
`define LPD_REG_IRQ_STAT 4'h3
`define LPD_REG_IRQ_EN   4'h4
`define LPD_REG_IRQ_CLR  4'h5
// Control bit positions.
`define LPD_CTRL_BUF     0
`define LPD_CTRL_SENSE   1
// Status bit positions.
`define LPD_ST_ATTN      0
`define LPD_ST_UCHK      1
`define LPD_ST_DET       2
`define LPD_ST_HALT      3
`define LPD_ST_GRAPH     4
`define LPD_ST_CHAR      5
// Interrupt event bit positions.
`define LPD_EV_DET       0
`define LPD_EV_UCHK      1
`endif

/* core/lpd_backstep.v */
// Light-pen detect trigger, address back-step and status toward the channel.
`timescale 1ns/100ps
`default_nettype none
`include "lpd_defs.vh"
module lpd_backstep (
   // Clock and reset
   input  wire        clk,
   input  wire        sys_rst,
   // Pen pins (asynchronous)
   input  wire        pen_photocell_amp,
   input  wire        foot_switch_n,
   // Regeneration datapath
   input  wire [7:0]  b_reg,
   input  wire        byte_read,
   input  wire        char_sample,
   input  wire        graph_sample,
   input  wire        sm_sample,
   input  wire        mode_char_set,
   input  wire        mode_graph_set,
   input  wire        addr_load,
   input  wire [11:0] addr_load_val,
   // Regeneration control outputs
   output wire [11:0] buffer_address_counter,
   output wire        regen_halt,
   output wire        mode_char,
   output wire        mode_graph,
   // Register port
   input  wire [3:0]  reg_addr,
   input  wire [15:0] reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output wire [15:0] reg_rdata,
   // Interrupt
   output wire        irq
);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   reg pen_s1_q, pen_s2_q, foot_s1_q, foot_s2_q;
   always @(posedge clk) begin
      if (sys_rst) begin
         pen_s1_q  <= 1'b0;
         pen_s2_q  <= 1'b0;
         foot_s1_q <= 1'b0;
         foot_s2_q <= 1'b0;
      end else begin
         pen_s1_q  <= pen_photocell_amp;
         pen_s2_q  <= pen_s1_q;
         foot_s1_q <= ~foot_switch_n;
         foot_s2_q <= foot_s1_q;
      end
   end

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   localparam ST_RUN  = 3'b001;
   localparam ST_STEP = 3'b010;
   localparam ST_WAIT = 3'b100;

   reg  [2:0]  state_q;
   reg  [11:0] bac_q;
   reg  [3:0]  loop_q;
   reg         enable_q, detect_q, attn_q, uchk_q, halt_q;
   reg         mchar_q, mgraph_q, buf_q;
   reg  [1:0]  ev_q, en_q;
   reg  [15:0] rdata_q;

   wire start_seen = (b_reg == `LPD_START_CODE);
   wire sample_any = char_sample | graph_sample | sm_sample;
   wire hit        = (state_q == ST_RUN) & detect_q & sample_any;
   wire sense_wr   = reg_wr & (reg_addr == `LPD_REG_CTRL) & reg_wdata[`LPD_CTRL_SENSE];
   wire ev_det     = hit;
   wire ev_uchk    = (state_q == ST_STEP) & (loop_q <= 4'h1);

   reg [3:0] back_cnt;
   always @* begin
      back_cnt = `LPD_BACK_CHAR;
      if (graph_sample) begin
         back_cnt = `LPD_BACK_GRAPH;
      end else if (sm_sample & mgraph_q) begin
         back_cnt = `LPD_BACK_SM_GR;
      end
   end

   // ----------------------------------------------------------------
   // Detection, back-step sequencer and counter
   // ----------------------------------------------------------------
   always @(posedge clk) begin
      if (sys_rst) begin
         state_q  <= ST_RUN;
         bac_q    <= `LPD_ADDR_RST;
         loop_q   <= 4'h0;
         enable_q <= 1'b0;
         detect_q <= 1'b0;
         attn_q   <= 1'b0;
         uchk_q   <= 1'b0;
         halt_q   <= 1'b0;
         mchar_q  <= 1'b0;
         mgraph_q <= 1'b0;
      end else begin
         // Detection window opens on the start code while the switch is held.
         if (!foot_s2_q) begin
            enable_q <= 1'b0;
         end else if (start_seen) begin
            enable_q <= 1'b1;
         end
         if (enable_q & foot_s2_q & pen_s2_q & (state_q == ST_RUN)) begin
            detect_q <= 1'b1;
         end
         if (mode_char_set) begin
            mchar_q  <= 1'b1;
            mgraph_q <= 1'b0;
         end else if (mode_graph_set) begin
            mchar_q  <= 1'b0;
            mgraph_q <= 1'b1;
         end else if (sm_sample & !hit) begin
            mchar_q  <= 1'b0;
            mgraph_q <= 1'b0;
         end // latches stay set when the pen is seen at a mode code.
         case (state_q)
            ST_RUN: begin
               if (addr_load) begin
                  bac_q <= addr_load_val;
               end else if (byte_read) begin
                  bac_q <= bac_q + 12'h001;
               end
               if (hit) begin
                  loop_q  <= buf_q ? back_cnt : 4'h1;
                  state_q <= ST_STEP;
               end
            end
            ST_STEP: begin
               // Nonbuffered runs one pass of the loop without touching the address.
               if (buf_q) begin
                  bac_q <= bac_q - 12'h001;
               end
               loop_q <= loop_q - 4'h1;
               if (loop_q <= 4'h1) begin
                  attn_q  <= buf_q;
                  uchk_q  <= 1'b1;
                  halt_q  <= 1'b1;
                  state_q <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (sense_wr) begin
                  // Sense taken: address already reported, resume regeneration.
                  attn_q   <= 1'b0;
                  uchk_q   <= 1'b0;
                  halt_q   <= 1'b0;
                  detect_q <= 1'b0;
                  enable_q <= 1'b0;
                  state_q  <= ST_RUN;
               end
            end
            default: begin
               state_q <= ST_RUN;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Registers and interrupt
   // ----------------------------------------------------------------
   always @(posedge clk) begin
      if (sys_rst) begin
         buf_q   <= 1'b0;
         ev_q    <= 2'b00;
         en_q    <= 2'b00;
         rdata_q <= 16'h0000;
      end else begin
         if (reg_wr & (reg_addr == `LPD_REG_CTRL)) begin
            buf_q <= reg_wdata[`LPD_CTRL_BUF];
         end
         if (reg_wr & (reg_addr == `LPD_REG_IRQ_EN)) begin
            en_q <= reg_wdata[1:0];
         end
         // Set wins over a clear in the same cycle.
         if (reg_wr & (reg_addr == `LPD_REG_IRQ_CLR)) begin
            ev_q <= (ev_q & ~reg_wdata[1:0]) | {ev_uchk, ev_det};
         end else begin
            ev_q <= ev_q | {ev_uchk, ev_det};
         end
         rdata_q <= 16'h0000;
         if (reg_rd) begin
            if (reg_addr == `LPD_REG_CTRL) begin
               rdata_q <= {15'h0000, buf_q};
            end else if (reg_addr == `LPD_REG_STATUS) begin
               rdata_q <= {10'h000, mchar_q, mgraph_q, halt_q, detect_q, uchk_q, attn_q};
            end else if (reg_addr == `LPD_REG_ADDR) begin
               rdata_q <= {4'h0, bac_q};
            end else if (reg_addr == `LPD_REG_IRQ_STAT) begin
               rdata_q <= {14'h0000, ev_q};
            end else if (reg_addr == `LPD_REG_IRQ_EN) begin
               rdata_q <= {14'h0000, en_q};
            end
         end
      end
   end

   assign buffer_address_counter = bac_q;
   assign regen_halt             = halt_q;
   assign mode_char              = mchar_q;
   assign mode_graph             = mgraph_q;
   assign reg_rdata              = rdata_q;
   assign irq                    = |(ev_q & en_q);

endmodule
`default_nettype wire

/* tb/lpd_pen_model.sv */
// Photocell stand-in: a fire request lights it for four clocks.
`timescale 1ns/100ps
`default_nettype none
module lpd_pen_model (
   // Clock, request and photocell
   input  wire clk,
   input  wire fire,
   output wire pen_photocell_amp
);
   reg [3:0] sh_q = 4'h0;
   assign pen_photocell_amp = |sh_q;
   always @(posedge clk) sh_q <= {sh_q[2:0], fire};
endmodule
`default_nettype wire

/* tb/lpd_backstep_chk.sv */
// Assertions for the light-pen back-step block.
`timescale 1ns/100ps
`default_nettype none
module lpd_chk (
   // Clock, reset, datapath and register port
   input wire        clk, sys_rst, byte_read, char_sample, graph_sample, sm_sample,
   input wire        regen_halt, mode_graph, reg_wr, reg_rd,
   input wire [3:0]  reg_addr,
   input wire [11:0] buffer_address_counter,
   input wire [15:0] reg_wdata, reg_rdata
);
   wire [11:0] cnt = buffer_address_counter;
   wire        smp = char_sample || graph_sample || sm_sample;
   reg         buf_q;
   reg  [11:0] cap_q;
   reg  [3:0]  back_q;
   // Count and due step-back at the latest pen sampling point.
   always @(posedge clk) begin
      if (sys_rst) {buf_q, cap_q, back_q} <= 17'h0;
      else begin
         if (reg_wr && reg_addr == 4'h0) buf_q <= reg_wdata[0];
         if (smp) cap_q <= cnt;
         if (smp) back_q <= graph_sample ? 4'h8 : sm_sample && mode_graph ? 4'h5 : 4'h2;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   property p_step; byte_read && !regen_halt |=> cnt == $past(cnt) + 12'h1; endproperty
   a_step: assert property (p_step) else $error("step");
   property p_hold; regen_halt |=> $stable(cnt); endproperty
   a_hold: assert property (p_hold) else $error("hold");
   property p_back; $rose(regen_halt) && buf_q |-> cnt == cap_q - {8'h0, back_q}; endproperty
   a_back: assert property (p_back) else $error("back");
   property p_nbuf; $rose(regen_halt) && !buf_q |-> cnt == cap_q; endproperty
   a_nbuf: assert property (p_nbuf) else $error("nbuf");
   property p_mode; $rose(regen_halt) && back_q == 4'h5 |-> mode_graph; endproperty
   a_mode: assert property (p_mode) else $error("mode");
   property p_idle; !reg_rd |=> reg_rdata == 16'h0; endproperty
   a_idle: assert property (p_idle) else $error("idle");
   property p_gap; reg_rd && reg_addr > 4'h5 |=> reg_rdata == 16'h0; endproperty
   a_gap: assert property (p_gap) else $error("gap");
   property p_addr; reg_rd && reg_addr == 4'h2 |=> reg_rdata == {4'h0, $past(cnt)}; endproperty
   a_addr: assert property (p_addr) else $error("addr");
endmodule
bind lpd_backstep lpd_chk chk_u (.*);
`default_nettype wire

/* tb/lpd_backstep_tb.sv */
// Self-checking bench for the light-pen back-step block.
`timescale 1ns/100ps
`default_nettype none
module lpd_backstep_tb;
   reg         clk, sys_rst, foot_switch_n, byte_read, char_sample, graph_sample, sm_sample;
   reg         fire, mode_char_set, mode_graph_set, addr_load, reg_wr, reg_rd, en;
   reg  [7:0]  b_reg;
   reg  [3:0]  reg_addr;
   reg  [11:0] addr_load_val, e;
   reg  [15:0] reg_wdata, v;
   reg  [31:0] seed;
   wire        pen_photocell_amp, regen_halt, mode_char, mode_graph, irq;
   wire [11:0] buffer_address_counter;
   wire [15:0] reg_rdata;
   integer     n_fail, n_compared, i, j;
   lpd_backstep dut_u (.*);
   lpd_pen_model pen_u (.*);
   function [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function [11:0] back(input [1:0] k);
      return k == 2'h1 ? 12'h8 : k == 2'h2 ? 12'h5 : 12'h2;
   endfunction
   task chk(input [15:0] g, input [15:0] w);
      n_compared++;
      if (g !== w) begin
         n_fail++;
         $display("unexpected at %0t: %h, not %h", $time, g, w);
      end
   endtask
   task test_done;
      $display("%0d checks, %0d mismatches", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task wr(input [3:0] a, input [15:0] d);
      @(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge clk) reg_wr <= 1'b0;
   endtask
   task rd(input [3:0] a);
      @(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge clk) reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   task run(input b, input [1:0] k, input f, input cd);
      wr(4'h0, {15'h0, b});
      e = rnd();
      @(posedge clk) {addr_load, addr_load_val, sm_sample, foot_switch_n} <= {1'b1, e, 1'b1, !f};
      @(posedge clk) {addr_load, sm_sample, byte_read, mode_graph_set, mode_char_set} <= {3'h1, ^k, ~^k};
      @(posedge clk) {byte_read, mode_graph_set, mode_char_set} <= 3'h0;
      repeat (2) @(posedge clk);
      b_reg <= cd ? 8'h82 : 8'h83;
      @(posedge clk) {b_reg, fire} <= 9'h003;
      @(posedge clk) fire <= 1'b0;
      repeat (5) @(posedge clk);
      {char_sample, graph_sample, sm_sample} <= {k == 2'h0, k == 2'h1, k[1]};
      @(posedge clk) {char_sample, graph_sample, sm_sample} <= 3'h0;
      e = e + 12'h1 - (b & f & cd ? back(k) : 12'h0);
      for (j = 0; j < 12 && regen_halt !== 1'b1; j++) @(posedge clk);
      #1 chk({regen_halt, 3'h0, buffer_address_counter}, {f & cd, 3'h0, e});
      chk({14'h0, mode_char, mode_graph}, {14'h0, (k[1] & !(f & cd)) ? 2'h0 : {~^k, ^k}});
      if (f & cd) begin
         rd(4'h1);
         chk(v & 16'h003f, {10'h0, ~^k, ^k, 3'h7, b});
         rd(4'h2);
         chk({v[14:0], irq}, {3'h0, e, en});
         wr(4'h0, {14'h0, 1'b1, b});
         wr(4'h5, 16'h0003);
         #1 chk({14'h0, regen_halt, irq}, 16'h0);
      end
   endtask
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      repeat (5000) @(posedge clk);
      n_fail++;
      test_done;
   end
   initial begin
      {sys_rst, foot_switch_n, byte_read, char_sample, graph_sample, sm_sample, fire} = 7'h60;
      {mode_char_set, mode_graph_set, addr_load, reg_wr, reg_rd, en, b_reg, reg_addr} = 18'h0;
      {addr_load_val, reg_wdata, seed} = {28'h0, 32'h20};
      n_fail = 0;
      n_compared = 0;
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      rd(4'hf);
      chk(v, 16'h0);
      run(1'b1, 2'h1, 1'b1, 1'b1);
      wr(4'h4, 16'h0003);
      en = 1'b1;
      for (i = 0; i < 16; i++) begin
         v = rnd();
         run(i < 8 ? i[0] : v[0], i < 8 ? i[2:1] : v[2:1], 1'b1, 1'b1);
      end
      run(1'b1, 2'h2, 1'b0, 1'b1);
      run(1'b1, 2'h0, 1'b1, 1'b0);
      test_done;
   end
endmodule
`default_nettype wire
